// >>> common/asfr_defs.svh
`ifndef ASFR_DEFS_SVH
`define ASFR_DEFS_SVH
`define ASFR_BIT_C 0
`define ASFR_BIT_HC 1
`define ASFR_BIT_Z 2
`define ASFR_BIT_WRAP 3
`define ASFR_BIT_N 4
`define ASFR_IMPL_MASK 5'h1f
`define ASFR_RST_VAL 5'h00
`endif

// >>> common/asfr_pkg.sv
package asfr_pkg;
  typedef enum logic [3:0] {
    ASFR_OP_NONE = 4'h0, // no flag effect
    ASFR_OP_ADD = 4'h1,
    ASFR_OP_SUB = 4'h2, // a minus b
    ASFR_OP_LOGIC = 4'h3, // z and n only
    ASFR_OP_ROR = 4'h4,
    ASFR_OP_ROL = 4'h5,
    ASFR_OP_CLR = 4'h6, // file clear
    ASFR_OP_INC = 4'h7 // add path, all flags
  } asfr_op_e;
  typedef logic [7:0] asfr_byte_t;
endpackage

// >>> core/asfr_adder.sv
`include "asfr_defs.svh"
module asfr_adder (
  input wire logic [7:0] a, // first operand
  input wire logic [7:0] b, // second operand
  input wire logic sub, // subtract a - b
  output logic [7:0] sum, // result
  output logic c, // carry out of msb
  output logic hc, // carry out of bit 3
  output logic wrap // signed overflow
);
  wire [7:0] b_eff = sub ? ~b : b;
  wire [4:0] lo = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, sub};
  wire [4:0] hi = {1'b0, a[7:4]} + {1'b0, b_eff[7:4]} + {4'h0, lo[4]};
  assign sum = {hi[3:0], lo[3:0]};
  assign hc = lo[4];
  assign c = hi[4];
  assign wrap = (a[7] == b_eff[7]) && (sum[7] != a[7]);
endmodule

// >>> core/asfr_rotate.sv
`include "asfr_defs.svh"
module asfr_rotate (
  input wire logic [7:0] src, // source register
  input wire logic cin, // current carry
  input wire logic left, // rotate left when high
  output logic [7:0] res, // rotated value
  output logic c, // bit shifted out
  output logic hc // source bit 3 or 4
);
  assign res = left ? {src[6:0], cin} : {cin, src[7:1]};
  assign c = left ? src[7] : src[0];
  assign hc = left ? src[3] : src[4];
endmodule

// >>> core/asfr_flags.sv
`include "asfr_defs.svh"
module asfr_flags (
  input wire logic clk, // core clock
  input wire logic arst_n, // async reset
  input wire asfr_pkg::asfr_op_e op, // flag-affecting operation
  input wire logic [7:0] opa, // operand a / rotate source
  input wire logic [7:0] opb, // operand b
  input wire logic wr_en, // instruction writes flag register
  input wire logic [7:0] wr_data, // data for that write
  output logic [7:0] flags, // register readback
  output logic [7:0] result // alu result
);
  import asfr_pkg::*;
  logic rst_s1_q, rst_n_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end
  logic [4:0] flag_q;
  logic [4:0] flag_d;
  logic [7:0] res_q;
  wire [7:0] add_sum, rot_res;
  wire add_c, add_hc, add_wrap, rot_c, rot_hc;
  wire is_sub = (op == ASFR_OP_SUB);
  wire [7:0] add_b = (op == ASFR_OP_INC) ? 8'h01 : opb;
  asfr_adder u_add (
    .a(opa),
    .b(add_b),
    .sub(is_sub),
    .sum(add_sum),
    .c(add_c),
    .hc(add_hc),
    .wrap(add_wrap)
  );
  asfr_rotate u_rot (
    .src(opa),
    .cin(flag_q[`ASFR_BIT_C]),
    .left(op == ASFR_OP_ROL),
    .res(rot_res),
    .c(rot_c),
    .hc(rot_hc)
  );
  wire arith = (op == ASFR_OP_ADD) || (op == ASFR_OP_SUB) || (op == ASFR_OP_INC);
  wire rot = (op == ASFR_OP_ROR) || (op == ASFR_OP_ROL);
  wire [7:0] alu_res = arith ? add_sum : rot ? rot_res :
                       (op == ASFR_OP_LOGIC) ? opa : 8'h00;
  // write of instruction data only where no flag comes from logic, and never on clear
  wire [4:0] wr_base = wr_en ? (wr_data[4:0] & `ASFR_IMPL_MASK) : flag_q;
  always_comb begin
    flag_d = wr_base;
    case (op)
      ASFR_OP_ADD, ASFR_OP_SUB, ASFR_OP_INC: begin
        flag_d = {alu_res[7], add_wrap, alu_res == 8'h00, add_hc, add_c};
      end
      ASFR_OP_ROR, ASFR_OP_ROL: begin
        flag_d[`ASFR_BIT_C] = rot_c;
        flag_d[`ASFR_BIT_HC] = rot_hc;
        flag_d[`ASFR_BIT_N] = rot_res[7];
        flag_d[`ASFR_BIT_Z] = (rot_res == 8'h00);
      end
      ASFR_OP_LOGIC: begin
        flag_d[`ASFR_BIT_N] = alu_res[7];
        flag_d[`ASFR_BIT_Z] = (alu_res == 8'h00);
      end
      ASFR_OP_CLR: begin
        flag_d = flag_q; // clear's zero write is suppressed too
        flag_d[`ASFR_BIT_Z] = 1'b1;
      end
      default: begin
        flag_d = wr_base;
      end
    endcase
  end
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      flag_q <= `ASFR_RST_VAL;
      res_q <= 8'h00;
    end else begin
      flag_q <= flag_d;
      res_q <= alu_res;
    end
  end
  assign flags = {3'b000, flag_q};
  assign result = res_q;

  a_clr_sets_z: assert property (@(posedge clk) disable iff (!rst_n_q)
    op == ASFR_OP_CLR |=> flags[`ASFR_BIT_Z] && flags[1:0] == $past(flags[1:0])
      && flags[4:3] == $past(flags[4:3]))
    else $error("clear did not set zero");
  a_upper_zero: assert property (@(posedge clk) disable iff (!rst_n_q)
    flags[7:5] == 3'b000) else $error("upper bits nonzero");
  a_quiet_write: assert property (@(posedge clk) disable iff (!rst_n_q)
    op == ASFR_OP_NONE && wr_en |=> flags[4:0] == $past(wr_data[4:0]))
    else $error("plain write lost");
  a_add_suppress: assert property (@(posedge clk) disable iff (!rst_n_q)
    op == ASFR_OP_ADD && wr_en |=> flags[`ASFR_BIT_Z] == (result == 8'h00))
    else $error("flag write not suppressed");
  a_sign_flag: assert property (@(posedge clk) disable iff (!rst_n_q)
    op == ASFR_OP_LOGIC |=> flags[`ASFR_BIT_N] == result[7])
    else $error("sign flag wrong");
  a_borrow_pol: assert property (@(posedge clk) disable iff (!rst_n_q)
    op == ASFR_OP_SUB |=> flags[`ASFR_BIT_C] == ($past(opa) >= $past(opb)))
    else $error("borrow polarity wrong");
  a_rot_carry: assert property (@(posedge clk) disable iff (!rst_n_q)
    op == ASFR_OP_ROR |=> flags[`ASFR_BIT_C] == $past(opa[0])
      && flags[`ASFR_BIT_HC] == $past(opa[4]))
    else $error("rotate right carry wrong");
  a_rot_left: assert property (@(posedge clk) disable iff (!rst_n_q)
    op == ASFR_OP_ROL |=> flags[`ASFR_BIT_HC] == $past(opa[3]))
    else $error("rotate left half carry wrong");
  a_rol_carry: assert property (@(posedge clk) disable iff (!rst_n_q)
    op == ASFR_OP_ROL |=> flags[`ASFR_BIT_C] == $past(opa[7]))
    else $error("rotate left carry wrong");
  a_inc_carry: assert property (@(posedge clk) disable iff (!rst_n_q)
    op == ASFR_OP_INC |=> flags[`ASFR_BIT_C] == ($past(opa) == 8'hff))
    else $error("increment carry wrong");
  a_half_carry: assert property (@(posedge clk) disable iff (!rst_n_q)
    op == ASFR_OP_ADD |=> flags[`ASFR_BIT_HC] == ({1'b0, $past(opa[3:0])}
      + {1'b0, $past(opb[3:0])} > 5'h0f))
    else $error("add half carry wrong");
  a_wrap_flag: assert property (@(posedge clk) disable iff (!rst_n_q)
    op == ASFR_OP_ADD |=> flags[`ASFR_BIT_WRAP] == (($past(opa[7]) == $past(opb[7]))
      && (result[7] != $past(opa[7]))))
    else $error("add overflow wrong");
  a_zero_logic: assert property (@(posedge clk) disable iff (!rst_n_q)
    op == ASFR_OP_LOGIC |=> flags[`ASFR_BIT_Z] == ($past(opa) == 8'h00))
    else $error("zero flag wrong");
  a_idle_hold: assert property (@(posedge clk) disable iff (!rst_n_q)
    op == ASFR_OP_NONE && !wr_en |=> flags == $past(flags))
    else $error("idle flags changed");
  a_add_carry: assert property (@(posedge clk) disable iff (!rst_n_q)
    op == ASFR_OP_ADD |=> flags[`ASFR_BIT_C] == ({1'b0, $past(opa)} + {1'b0, $past(opb)} > 9'h0ff))
    else $error("add carry wrong");
endmodule

// >>> sim/asfr_core_model.sv
module asfr_core_model (
  output asfr_pkg::asfr_op_e op, // current operation
  output logic [7:0] opa, // operand a
  output logic [7:0] opb, // operand b
  output logic wr_en, // register write strobe
  output logic [7:0] wr_data // write data
);
  timeunit 1ns;
  timeprecision 1ps;
  import asfr_pkg::*;
  initial drive(ASFR_OP_NONE, 8'h00, 8'h00, 1'b0, 8'h00);
  // one instruction a cycle, back to back, like the real core
  task drive(asfr_op_e o, logic [7:0] a, logic [7:0] b, logic w, logic [7:0] d);
    op = o;
    opa = a;
    opb = b;
    wr_en = w;
    wr_data = d;
  endtask
endmodule

// >>> sim/alu_status_flag_register_tb_top.sv
module alu_status_flag_register_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import asfr_pkg::*;
`define CHK(n, e, g) begin checked++; if ((g) !== 8'(e)) begin fail_count++; \
  $display("[FAIL] %s exp %h got %h", n, 8'(e), g); end end
  logic clk = 0, arst_n = 0, wr_en;
  asfr_op_e op;
  logic [7:0] opa, opb, wr_data, flags, result;
  int fail_count = 0, checked = 0, f = 0, r = 0;
  always #12.5 clk = ~clk;
  asfr_core_model asfr_core_model_inst (.op(op), .opa(opa), .opb(opb), .wr_en(wr_en),
    .wr_data(wr_data));
  asfr_flags asfr_flags_inst (.clk(clk), .arst_n(arst_n), .op(op), .opa(opa), .opb(opb),
    .wr_en(wr_en), .wr_data(wr_data), .flags(flags), .result(result));
  task automatic step(asfr_op_e o, int a, int b, int w, int d);
    int x, s, ci, c0;
    @(negedge clk);
    `CHK("flags", f, flags)
    `CHK("result", r, result)
    asfr_core_model_inst.drive(o, 8'(a), 8'(b), w[0], 8'(d));
    c0 = f & 1;
    if (w && o != ASFR_OP_CLR) f = d & 'h1f;
    ci = o == ASFR_OP_SUB;
    x = ci ? b ^ 255 : (o == ASFR_OP_INC ? 1 : b);
    r = 0;
    case (o)
      ASFR_OP_ADD, ASFR_OP_SUB, ASFR_OP_INC: begin
        s = a + x + ci;
        r = s & 255;
        f = (s >> 8) | (((a & 15) + (x & 15) + ci) >> 4 << 1) | (((a ^ r) & (x ^ r)) >> 7 << 3);
      end
      ASFR_OP_LOGIC: r = a;
      ASFR_OP_ROR: begin
        r = (a >> 1) | (c0 << 7);
        f = (f & 8) | (a & 1) | ((a >> 4 & 1) << 1);
      end
      ASFR_OP_ROL: begin
        r = (a << 1 & 255) | c0;
        f = (f & 8) | (a >> 7) | ((a >> 3 & 1) << 1);
      end
      ASFR_OP_CLR: f = f | 4;
      default: ;
    endcase
    if (o inside {[ASFR_OP_ADD:ASFR_OP_ROL], ASFR_OP_INC})
      f = (f & 'h0b) | ((r == 0) << 2) | (r >> 7 << 4);
  endtask
  task end_of_test;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    void'($urandom(41820));
    repeat (12) @(posedge clk);
    @(negedge clk) arst_n = 1;
    repeat (3) @(posedge clk);
    step(ASFR_OP_ADD, 'h7f, 1, 0, 0);
    step(ASFR_OP_NONE, 0, 0, 1, 'hff); // upper three bits must stay zero
    step(ASFR_OP_CLR, 0, 0, 1, 0);
    step(ASFR_OP_SUB, 0, 1, 1, 'h1f);
    step(ASFR_OP_SUB, 'h80, 1, 0, 0);
    step(ASFR_OP_LOGIC, 0, 0, 1, 'h1b);
    step(ASFR_OP_ROR, 'h11, 0, 0, 0);
    step(ASFR_OP_ROL, 'h88, 0, 0, 0);
    step(ASFR_OP_INC, 'hff, 0, 1, 'h10);
    $display("test directed done");
    repeat (300) step(asfr_op_e'($urandom % 8), $urandom % 256, $urandom % 256, $urandom % 2,
      $urandom % 256);
    step(ASFR_OP_NONE, 0, 0, 0, 0);
    $display("test random done");
    end_of_test();
  end
  initial begin
    #20000;
    fail_count++;
    end_of_test();
  end
endmodule
